// File: verilog/hzb_control.sv
`timescale 1ns/100ps
// Operation
// RULE_01: fetch-visible effects of executed instructions are tracked apart from execution effects.
// RULE_02: address-space id or watch write blocks fetch until visible, five cycles; here it only sets the five-cycle hazard, fetch stalls only behind a barrier.
// RULE_03: status write, including error level change, reaches fetch within five cycles.
// RULE_04: indexed or random translation write reaches fetch after hazard clears.
// RULE_05: instruction-cache maintenance reaches fetch after hazard clears, five cycles.
// RULE_06: icache sync makes stream coherent; without it hazard stays pending.
// RULE_07: previous shadow set write hazards later previous-shadow register accesses.
// RULE_08: exception and debug return clear both hazard kinds.
// RULE_09: hazard-barrier jumps clear both hazard kinds before target proceeds.
// RULE_10: returns do not guard their own inputs; software spaces those writes.
// RULE_11: exceptions and interrupts clear all hazards before the handler.
// RULE_12: execution barrier clears execution hazards only; encoded as no-op variant.
// RULE_13: barrier jumps are marked by bit 10 of the hint field.
// RULE_14: icache sync decodes under register-immediate opcode; legacy mode traps it.
// RULE_15: newer generation implements barrier, barrier jumps and sync.
// RULE_16: barriers stall or flush younger fetch until pending updates commit.
module hzb_control (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        legacy_mode,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic        exc_taken,
  input  wire logic        sync_done,
  output logic             fetch_stall,
  output logic             flush_younger,
  output logic             issue_stall,
  output logic             exec_clear,
  output logic             instr_clear,
  output logic             resv_exc
);

  hzb_pkg::hzb_state_s r_reg;
  hzb_pkg::hzb_state_s r_next;
  hzb_pkg::hzb_decode_s dec;

  logic [5:0] op;
  logic [5:0] fn;
  logic [4:0] rs;
  logic [4:0] rt;
  logic [4:0] rd;
  logic [4:0] sa;
  logic [2:0] sel;

  assign op  = instr_word[hzb_pkg::OP_HI:hzb_pkg::OP_LO];
  assign fn  = instr_word[hzb_pkg::FUNCT_HI:hzb_pkg::FUNCT_LO];
  assign rs  = instr_word[hzb_pkg::RS_HI:hzb_pkg::RS_LO];
  assign rt  = instr_word[hzb_pkg::RT_HI:hzb_pkg::RT_LO];
  assign rd  = instr_word[hzb_pkg::RD_HI:hzb_pkg::RD_LO];
  assign sa  = instr_word[hzb_pkg::SHAMT_HI:hzb_pkg::SHAMT_LO];
  assign sel = instr_word[hzb_pkg::SEL_HI:hzb_pkg::SEL_LO];

  // instruction classes, one name per form so each rule reads off a single term
  logic is_cop0;
  logic is_special;
  logic is_mt;
  logic is_co;
  logic zero_top;
  logic jump;
  logic hint_barrier;
  logic wr_entry_hi;
  logic wr_watch;
  logic wr_status;
  logic wr_shadow;
  logic xlate_form;
  logic ret_form;
  logic prev_form;
  logic nop_form;
  logic sync_form;

  assign is_cop0      = (op == hzb_pkg::OPC_COP0);
  assign is_special   = (op == hzb_pkg::OPC_SPECIAL);
  assign is_mt        = is_cop0 && (rs == hzb_pkg::RS_MT);
  assign is_co        = is_cop0 && instr_word[hzb_pkg::RS_HI];
  assign zero_top     = (rs == 5'h00) && (rt == 5'h00) && (rd == 5'h00);
  assign jump         = is_special && ((fn == hzb_pkg::FN_JR) || (fn == hzb_pkg::FN_JALR));
  // legacy cores ignore the hint and run a plain jump
  assign hint_barrier = jump && instr_word[hzb_pkg::HINT_HB] && !legacy_mode; // RULE_13 RULE_15
  // entry-high is tracked whole: the address-space id part cannot be told apart here
  assign wr_entry_hi  = is_mt && (rd == hzb_pkg::REG_ENTRY_HI);
  assign wr_watch     = is_mt && ((rd == hzb_pkg::REG_WATCH_LO) || (rd == hzb_pkg::REG_WATCH_HI));
  assign wr_status    = is_mt && (rd == hzb_pkg::REG_STATUS) && (sel == hzb_pkg::SEL_STATUS);
  assign wr_shadow    = is_mt && (rd == hzb_pkg::REG_SHADOW_SET_CONTROL_REG) && (sel == hzb_pkg::SEL_SHADOW_SET_CONTROL_REG);
  assign xlate_form   = is_co && ((fn == hzb_pkg::FN_XLATE_WRITE_INDEXED_INSTR) || (fn == hzb_pkg::FN_XLATE_WRITE_RANDOM_INSTR));
  assign ret_form     = is_co && ((fn == hzb_pkg::FN_EXCEPTION_RETURN_INSTR) || (fn == hzb_pkg::FN_DEBUG_RETURN_INSTR));
  assign prev_form    = is_cop0 && ((rs == hzb_pkg::RS_READ_PREV_SHADOW_GPR_INSTR) || (rs == hzb_pkg::RS_WRITE_PREV_SHADOW_GPR_INSTR));
  assign nop_form     = is_special && (fn == hzb_pkg::FN_SLL) && zero_top;
  assign sync_form    = (op == hzb_pkg::OPC_REGISTER_IMMEDIATE_OPCODE) && (rt == hzb_pkg::RT_ICACHE_SYNC_INSTR);

  always_comb begin
    dec = '0;
    if (instr_valid) begin
      dec.sysctl_write = wr_entry_hi || wr_watch; // RULE_02
      if (wr_status) begin
        dec.sysctl_write = 1'b1; // RULE_03
      end
      dec.pss_write = wr_shadow; // RULE_07
      dec.xlate_write = xlate_form; // RULE_04
      dec.cache_op = (op == hzb_pkg::OPC_CACHE); // RULE_05
      dec.prev_gpr = prev_form;
      dec.full_barrier = ret_form; // RULE_08
      if (hint_barrier) begin
        dec.full_barrier = 1'b1; // RULE_09
      end
      // legacy cores see the barrier as a harmless no-op RULE_12
      if (nop_form) begin
        dec.superscalar_noop_instr = (sa == hzb_pkg::SHAMT_SUPERSCALAR_NOOP_INSTR);
        dec.exec_barrier = (sa == hzb_pkg::SHAMT_EHB) && !legacy_mode; // RULE_15
      end
      // reserved in legacy mode so a kernel can emulate it with cache operations RULE_14
      if (sync_form) begin
        dec.icache_sync = !legacy_mode;
        dec.reserved_instr = legacy_mode;
      end
    end
  end

  always_comb begin
    r_next = r_reg;
    r_next.exec_clear = 1'b0;
    r_next.instr_clear = 1'b0;
    r_next.resv_exc = dec.reserved_instr; // RULE_14
    r_next.flush_younger = 1'b0;

    // RULE_01 fetch-side hazards, timed window
    if (dec.sysctl_write || dec.xlate_write || dec.cache_op) begin
      r_next.ifetch_pend = 1'b1;
      r_next.exec_pend = 1'b1;
      r_next.cnt = hzb_pkg::HAZ_CNT_INIT;
    end else if (r_reg.cnt != 3'h0) begin
      r_next.cnt = r_reg.cnt - 3'h1;
      if (r_reg.cnt == 3'h1) begin
        r_next.ifetch_pend = 1'b0;
        r_next.exec_pend = 1'b0;
      end
    end
    if (dec.pss_write) begin
      r_next.pss_pend = 1'b1; // RULE_07
    end
    // unbounded until the sync completes RULE_06
    if (dec.icache_sync) begin
      r_next.sync_pend = 1'b1;
    end else if (sync_done) begin
      r_next.sync_pend = 1'b0;
    end

    case (r_reg.state)
      hzb_pkg::HZB_IDLE: begin
        if (dec.full_barrier || dec.icache_sync) begin
          r_next.state = hzb_pkg::HZB_DRAIN;
          r_next.flush_younger = 1'b1; // RULE_16
        end else if (dec.exec_barrier) begin
          r_next.exec_pend = 1'b0; // RULE_12
          r_next.exec_clear = 1'b1;
        end
      end
      hzb_pkg::HZB_DRAIN: begin
        // a barrier behind the one draining shares its drain; drop what it let in
        if (dec.full_barrier || dec.icache_sync) begin
          r_next.flush_younger = 1'b1; // RULE_16
        end else if (dec.exec_barrier) begin
          r_next.exec_pend = 1'b0; // RULE_12
          r_next.exec_clear = 1'b1;
        end
        // hold fetch until every update has reached the fetch stage RULE_16
        if (!r_next.ifetch_pend && !r_next.sync_pend) begin
          r_next.state = hzb_pkg::HZB_HOLD;
        end
      end
      hzb_pkg::HZB_HOLD: begin
        r_next.state = hzb_pkg::HZB_IDLE;
        r_next.exec_clear = 1'b1; // RULE_08 RULE_09
        r_next.instr_clear = 1'b1;
        // a shadow-set write in this very cycle stays pending: the set wins
        r_next.pss_pend = dec.pss_write; // RULE_07
        // a barrier taken in the last stall cycle starts a drain of its own
        if (dec.full_barrier || dec.icache_sync) begin
          r_next.state = hzb_pkg::HZB_DRAIN;
          r_next.flush_younger = 1'b1; // RULE_16
        end
      end
      default: begin
        r_next.state = hzb_pkg::HZB_IDLE;
      end
    endcase

    // a barrier entered the drain state; new producers behind it still reload the counter and lengthen the drain
    // RULE_11 exception overrides state, counter and every pending hazard; only resv_exc is left as decoded
    if (exc_taken) begin
      r_next.state = hzb_pkg::HZB_IDLE;
      r_next.cnt = 3'h0;
      r_next.ifetch_pend = 1'b0;
      r_next.exec_pend = 1'b0;
      r_next.pss_pend = 1'b0;
      r_next.sync_pend = 1'b0;
      r_next.exec_clear = 1'b1;
      r_next.instr_clear = 1'b1;
      r_next.flush_younger = 1'b1;
    end

    r_next.fetch_stall = (r_next.state != hzb_pkg::HZB_IDLE); // RULE_16
    // previous-shadow access waits while the set change is in flight RULE_07
    r_next.issue_stall = r_next.pss_pend && dec.prev_gpr;
    // returns do not check their own inputs; software spaces those writes RULE_10
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign fetch_stall   = r_reg.fetch_stall;
  assign flush_younger = r_reg.flush_younger;
  assign issue_stall   = r_reg.issue_stall;
  assign exec_clear    = r_reg.exec_clear;
  assign instr_clear   = r_reg.instr_clear;
  assign resv_exc      = r_reg.resv_exc;

endmodule

// File: verilog/hzb_pkg.sv
package hzb_pkg;

  // instruction word fields
  localparam int unsigned OP_HI      = 31;
  localparam int unsigned OP_LO      = 26;
  localparam int unsigned RT_HI      = 20;
  localparam int unsigned RT_LO      = 16;
  localparam int unsigned FUNCT_HI   = 5;
  localparam int unsigned FUNCT_LO   = 0;
  localparam int unsigned SHAMT_HI   = 10;
  localparam int unsigned SHAMT_LO   = 6;
  localparam int unsigned HINT_HB    = 10;
  localparam int unsigned RS_HI      = 25;
  localparam int unsigned RS_LO      = 21;
  localparam int unsigned RD_HI      = 15;
  localparam int unsigned RD_LO      = 11;
  localparam int unsigned SEL_HI     = 2;
  localparam int unsigned SEL_LO     = 0;

  localparam logic [5:0] OPC_SPECIAL  = 6'h00;
  localparam logic [5:0] OPC_REGISTER_IMMEDIATE_OPCODE   = 6'h01;
  localparam logic [5:0] OPC_COP0     = 6'h10;
  localparam logic [5:0] OPC_CACHE    = 6'h2F;
  localparam logic [5:0] FN_SLL       = 6'h00;
  localparam logic [5:0] FN_JR        = 6'h08;
  localparam logic [5:0] FN_JALR      = 6'h09;
  localparam logic [5:0] FN_EXCEPTION_RETURN_INSTR      = 6'h18;
  localparam logic [5:0] FN_DEBUG_RETURN_INSTR     = 6'h1F;
  localparam logic [5:0] FN_XLATE_WRITE_INDEXED_INSTR     = 6'h02;
  localparam logic [5:0] FN_XLATE_WRITE_RANDOM_INSTR     = 6'h06;
  localparam logic [4:0] RS_MT        = 5'h04;
  localparam logic [4:0] RS_READ_PREV_SHADOW_GPR_INSTR    = 5'h0A;
  localparam logic [4:0] RS_WRITE_PREV_SHADOW_GPR_INSTR    = 5'h0E;
  localparam logic [4:0] RT_ICACHE_SYNC_INSTR     = 5'h1F;
  localparam logic [4:0] SHAMT_SUPERSCALAR_NOOP_INSTR  = 5'h01;
  localparam logic [4:0] SHAMT_EHB    = 5'h03;
  localparam logic [4:0] REG_ENTRY_HI = 5'h0A;
  localparam logic [4:0] REG_STATUS   = 5'h0C;
  localparam logic [4:0] REG_SHADOW_SET_CONTROL_REG   = 5'h0C;
  localparam logic [2:0] SEL_SHADOW_SET_CONTROL_REG   = 3'h2;
  localparam logic [2:0] SEL_STATUS   = 3'h0;
  localparam logic [4:0] REG_WATCH_LO = 5'h12;
  localparam logic [4:0] REG_WATCH_HI = 5'h13;

  // hazard window: figure in cycles, derived from the clock period
  localparam int unsigned HAZ_SPACING_CYC = 5;
  localparam int unsigned MCLK_NS         = 10;
  localparam int unsigned HAZ_SPACING_NS  = HAZ_SPACING_CYC * MCLK_NS;
  localparam int unsigned HAZ_CYCLES      = (HAZ_SPACING_NS + MCLK_NS - 1) / MCLK_NS;
  localparam logic [2:0]  HAZ_CNT_INIT    = 3'(HAZ_CYCLES);

  typedef enum logic [1:0] {
    HZB_IDLE  = 2'b00,
    HZB_DRAIN = 2'b01,
    HZB_HOLD  = 2'b11
  } hzb_state_e;

  typedef struct packed {
    logic sysctl_write;
    logic xlate_write;
    logic cache_op;
    logic icache_sync;
    logic exec_barrier;
    logic full_barrier;
    logic superscalar_noop_instr;
    logic prev_gpr;
    logic pss_write;
    logic reserved_instr;
  } hzb_decode_s;

  typedef struct packed {
    hzb_state_e state;
    logic [2:0] cnt;
    logic       ifetch_pend;
    logic       exec_pend;
    logic       pss_pend;
    logic       sync_pend;
    logic       fetch_stall;
    logic       flush_younger;
    logic       issue_stall;
    logic       exec_clear;
    logic       instr_clear;
    logic       resv_exc;
  } hzb_state_s;

endpackage

// File: bench/hzb_control_monitor.sv
`timescale 1ns/100ps
module hzb_control_monitor (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        legacy_mode,
  input wire logic        instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic        exc_taken,
  input wire logic        sync_done,
  input wire logic        fetch_stall,
  input wire logic        flush_younger,
  input wire logic        issue_stall,
  input wire logic        exec_clear,
  input wire logic        instr_clear,
  input wire logic        resv_exc
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_status;
    instr_valid && instr_word == 32'h4080_6000;
  endsequence
  sequence s_ret;
    instr_valid && !exc_taken && (instr_word == 32'h4200_0018 || instr_word == 32'h4200_001F);
  endsequence
  property p_ret; s_ret |=> flush_younger && fetch_stall; endproperty
  a_ret: assert property (p_ret) else $error("return gave no flush");
  // stall must cover the last four cycles of the five-cycle window of the status write
  property p_drain; s_status ##1 s_ret |=> fetch_stall[*4] ##[1:4] instr_clear; endproperty
  a_drain: assert property (p_drain) else $error("status drain wrong");
  property p_fall; $fell(fetch_stall) |-> instr_clear && exec_clear; endproperty
  a_fall: assert property (p_fall) else $error("stall ended without clear");
  property p_exc; exc_taken |=> exec_clear && instr_clear && !fetch_stall; endproperty
  a_exc: assert property (p_exc) else $error("exception did not clear");
  property p_ehb; instr_valid && instr_word == 32'h0000_00C0 && !legacy_mode && !fetch_stall
    && !exc_taken |=> exec_clear && !instr_clear && !fetch_stall; endproperty
  a_ehb: assert property (p_ehb) else $error("execution barrier wrong");
  property p_resv; instr_valid && instr_word == 32'h041F_0000 && legacy_mode |=> resv_exc; endproperty
  a_resv: assert property (p_resv) else $error("sync not trapped");
  property p_hint; instr_valid && instr_word == 32'h03E0_0408 && legacy_mode && !fetch_stall
    && !exc_taken |=> !flush_younger; endproperty
  a_hint: assert property (p_hint) else $error("hint honoured in legacy");
  property p_pss; instr_valid && instr_word == 32'h4080_6002 ##1
    instr_valid && instr_word == 32'h41C0_0000 |=> issue_stall; endproperty
  a_pss: assert property (p_pss) else $error("shadow access not held");
endmodule

// File: bench/hzb_control_tb.sv
`timescale 1ns/100ps
module hzb_control_tb;
  logic mclk = 0, rst = 1, legacy_mode = 0, instr_valid = 0, exc_taken = 0, sync_done = 0;
  logic [31:0] instr_word = 32'h0000_0000;
  logic fetch_stall, flush_younger, issue_stall, exec_clear, instr_clear, resv_exc;
  int errors = 0, checks = 0, n;
  logic [31:0] prod [6] = '{32'h4080_5000, 32'h4080_9000, 32'h4200_0002, 32'hBC00_0000,
                            32'h4200_0006, 32'h4080_9800};
  logic [31:0] barr [6] = '{32'h4200_001F, 32'h03E0_0408, 32'h03E0_FC09, 32'h4200_0018,
                            32'h03E0_0408, 32'h03E0_FC09};
  hzb_control dut (.mclk(mclk), .rst(rst), .legacy_mode(legacy_mode),
    .instr_valid(instr_valid), .instr_word(instr_word), .exc_taken(exc_taken),
    .sync_done(sync_done), .fetch_stall(fetch_stall), .flush_younger(flush_younger),
    .issue_stall(issue_stall), .exec_clear(exec_clear), .instr_clear(instr_clear),
    .resv_exc(resv_exc));
  always #5 mclk = ~mclk;
  task automatic chk(input string nm, input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  // hold keeps valid up so the next send lands back to back
  task automatic send(input logic [31:0] w, input bit hold);
    @(negedge mclk);
    instr_valid = 1;
    instr_word = w;
    if (!hold) begin
      @(negedge mclk);
      instr_valid = 0;
    end
  endtask
  task automatic wait_clr();
    n = 0;
    while (instr_clear !== 1'b1 && n < 30) begin
      @(negedge mclk);
      n++;
    end
    chk("clear_both", exec_clear, 1);
    chk("stall_off", fetch_stall, 0);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_plain();
    send(32'h0000_00C0, 0);
    chk("ehb_exec", exec_clear, 1);
    chk("ehb_instr", instr_clear, 0);
    send(32'h0000_0040, 0);
    chk("superscalar_noop_instr", exec_clear | fetch_stall, 0);
    send(32'h03E0_0008, 0);
    chk("jr_plain", flush_younger, 0);
    $display("test plain done");
  endtask
  task automatic t_window();
    send(32'h4080_6000, 1);
    send(32'h4200_0018, 0);
    chk("ret_flush", flush_younger & fetch_stall, 1);
    wait_clr();
    chk("status_span", n inside {[4:8]}, 1);
    for (int i = 0; i < 6; i++) begin
      send(prod[i], 1);
      send(barr[i], 0);
      chk("hb_flush", flush_younger, 1);
      wait_clr();
      chk("prod_span", n inside {[4:8]}, 1);
    end
    $display("test window done");
  endtask
  task automatic t_misc();
    send(32'h041F_0000, 0);
    repeat (10) @(negedge mclk);
    chk("sync_hold", fetch_stall & ~instr_clear, 1);
    sync_done = 1;
    @(negedge mclk);
    sync_done = 0;
    wait_clr();
    chk("sync_end", n < 5, 1);
    send(32'h4080_7000, 1);
    send(32'h4200_0018, 0);
    chk("ret_flush2", flush_younger & fetch_stall, 1);
    wait_clr();
    chk("ret_unguarded", n == 2, 1);
    send(32'h4080_6002, 1);
    send(32'h41C0_0000, 0);
    chk("pss_wait", issue_stall, 1);
    send(32'h4140_0000, 0);
    chk("pss_read", issue_stall, 1);
    send(32'h4080_9000, 0);
    chk("pss_other", issue_stall, 0);
    exc_taken = 1;
    @(negedge mclk);
    exc_taken = 0;
    chk("exc_clear", instr_clear & exec_clear & flush_younger & ~fetch_stall, 1);
    $display("test misc done");
  endtask
  task automatic t_legacy();
    legacy_mode = 1;
    send(32'h041F_0000, 0);
    chk("resv", resv_exc & ~fetch_stall, 1);
    send(32'h03E0_0408, 0);
    chk("hint_off", flush_younger, 0);
    send(32'h0000_00C0, 0);
    chk("ehb_noop", exec_clear, 0);
    send(32'h4200_0018, 0);
    chk("exception_return_instr_old", flush_younger, 1);
    wait_clr();
    legacy_mode = 0;
    $display("test legacy done");
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    rst = 0;
    t_plain();
    t_window();
    t_misc();
    t_legacy();
    end_of_test();
  end
  // whole run is well under 400 cycles
  initial begin
    #20000;
    errors++;
    end_of_test();
  end
endmodule
bind hzb_control hzb_control_monitor u_mon (.mclk(mclk), .rst(rst), .legacy_mode(legacy_mode),
  .instr_valid(instr_valid), .instr_word(instr_word), .exc_taken(exc_taken),
  .sync_done(sync_done), .fetch_stall(fetch_stall), .flush_younger(flush_younger),
  .issue_stall(issue_stall), .exec_clear(exec_clear), .instr_clear(instr_clear),
  .resv_exc(resv_exc));
